/* sram_host.sv */
`default_nettype none
// Function
// - write mode set before strobe rises
// - read mode set before strobe rises
// - write data stable before strobe rises
// - address stable before strobe rises
// - inputs may change once strobe high
// - read strobe high at least 200 ns
// - write strobe high at least 200 ns
// - read recovery low at least 125 ns
// - write recovery low at least 125 ns
// - full strobe cycle at least 350 ns
module sram_host
    import sram_host_pkg::*;
#(
    parameter int AW = ADDR_WIDTH
) (
    // clock and reset
    input  wire logic          clk,
    input  wire logic          resetn,
    // user request
    input  wire logic          req_valid,
    output logic               req_ready,
    input  wire logic          req_write,
    input  wire logic [AW-1:0] req_addr,
    input  wire logic          req_wdata,
    // user answer
    output logic               rsp_valid,
    output logic               rsp_rdata,
    output logic               rsp_error,
    // memory pins
    output logic               sel_strobe,
    output logic               rw_sel,
    output logic [AW-1:0]      addr_pin,
    output logic               din_pin,
    input  wire logic          dout_pin,
    input  wire logic          doutn_pin
);
    ////////////////////////////////////////////////////////////////////////
    sram_pins_if pins ();

    state_type            state_q;
    state_type            state_d;
    logic                 write_q;
    logic                 strobe_q;
    logic                 rw_q;
    logic [AW-1:0]        addr_q;
    logic                 din_q;
    logic                 rdata_q;
    logic                 rvalid_q;
    logic                 rerror_q;
    logic                 width_load;
    logic                 width_done;
    logic                 cyc_load;
    logic                 cyc_done;
    logic [CNT_WIDTH-1:0] width_val;
    logic [CNT_WIDTH-1:0] rec_val;
    logic                 take;

    assign pins.sample = strobe_q;

    sram_out_sync u_sync (
        .clk       (clk),
        .resetn    (resetn),
        .dout_pin  (dout_pin),
        .doutn_pin (doutn_pin),
        .pins      (pins)
    );

    // width timer reused for recovery
    sram_timer u_width (
        .clk    (clk),
        .resetn (resetn),
        .load   (width_load),
        .value  (state_q == ST_IDLE ? width_val : rec_val),
        .done   (width_done)
    );

    sram_timer u_cycle (
        .clk    (clk),
        .resetn (resetn),
        .load   (cyc_load),
        .value  (CNT_WIDTH'(CYCLE_CYC - 1)),
        .done   (cyc_done)
    );

    ////////////////////////////////////////////////////////////////////////
    // read strobe width
    // write strobe width
    // full count: the zero reached drops the strobe, so high lasts the whole width
    assign width_val = req_write ? CNT_WIDTH'(WRITE_WIDTH_CYC)
                                 : CNT_WIDTH'(READ_WIDTH_CYC);
    assign rec_val   = write_q ? CNT_WIDTH'(WRITE_REC_CYC - 1)
                               : CNT_WIDTH'(READ_REC_CYC - 1);

    assign req_ready  = (state_q == ST_IDLE) && cyc_done;
    assign take       = req_valid && req_ready;
    assign width_load = take || ((state_q == ST_STROBE) && width_done);
    assign cyc_load   = take;

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (take) begin
                    state_d = ST_STROBE;
                end
            end
            ST_STROBE: begin
                if (width_done) begin
                    state_d = ST_RECOV;
                end
            end
            ST_RECOV: begin
                if (width_done) begin
                    state_d = ST_IDLE;
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // address, mode and data are set up one cycle before the strobe rises
    // write mode before strobe
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rw_q    <= 1'b0;
            addr_q  <= '0;
            din_q   <= 1'b0;
            write_q <= 1'b0;
        end else if (take) begin
            rw_q    <= req_write;
            addr_q  <= req_addr;
            din_q   <= req_write & req_wdata;
            write_q <= req_write;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            strobe_q <= 1'b0;
        end else if ((state_q == ST_STROBE) && !width_done) begin
            strobe_q <= 1'b1;
        end else begin
            strobe_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata_q  <= 1'b0;
            rvalid_q <= 1'b0;
            rerror_q <= 1'b0;
        end else begin
            rvalid_q <= 1'b0;
            if ((state_q == ST_STROBE) && width_done) begin
                rvalid_q <= 1'b1;
                rdata_q  <= !write_q && pins.dout_sync;
                rerror_q <= !write_q && (pins.dout_sync == pins.doutn_sync);
            end
        end
    end

    assign sel_strobe = strobe_q;
    assign rw_sel     = rw_q;
    assign addr_pin   = addr_q;
    assign din_pin    = din_q;
    assign rsp_valid  = rvalid_q;
    assign rsp_rdata  = rdata_q;
    assign rsp_error  = rerror_q;

    ////////////////////////////////////////////////////////////////////////
    logic [CNT_WIDTH-1:0] hi_cnt_q;
    logic [CNT_WIDTH-1:0] lo_cnt_q;
    logic [CNT_WIDTH-1:0] since_q;
    // low count starts saturated so the first access after reset is legal
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            hi_cnt_q <= CNT_ZERO;
            lo_cnt_q <= 8'hFF;
        end else begin
            hi_cnt_q <= strobe_q ? hi_cnt_q + 8'h01 : CNT_ZERO;
            lo_cnt_q <= strobe_q ? CNT_ZERO : ((lo_cnt_q == 8'hFF) ? lo_cnt_q : lo_cnt_q + 8'h01);
        end
    end

    // cycles since the last strobe rise, saturating
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            since_q <= 8'hFF;
        end else if (strobe_q && (hi_cnt_q == CNT_ZERO)) begin
            since_q <= 8'h01;
        end else if (since_q != 8'hFF) begin
            since_q <= since_q + 8'h01;
        end
    end

    a_strobe_width_min: assert property (
        @(posedge clk) disable iff (!resetn)
        $fell(strobe_q) |-> hi_cnt_q >= CNT_WIDTH'(READ_WIDTH_CYC))
        else $error("strobe high too short");

    a_write_width_min: assert property (
        @(posedge clk) disable iff (!resetn)
        ($fell(strobe_q) && write_q) |-> hi_cnt_q >= CNT_WIDTH'(WRITE_WIDTH_CYC))
        else $error("write strobe too short");

    a_recovery_min: assert property (
        @(posedge clk) disable iff (!resetn)
        $rose(strobe_q) |-> lo_cnt_q >= CNT_WIDTH'(READ_REC_CYC))
        else $error("strobe low too short");

    a_setup_before: assert property (
        @(posedge clk) disable iff (!resetn)
        $rose(strobe_q) |-> $stable(addr_pin) && $stable(rw_sel) && $stable(din_pin))
        else $error("inputs moved at strobe rise");

    a_hold_during: assert property (
        @(posedge clk) disable iff (!resetn)
        strobe_q |=> (!strobe_q || $stable(addr_pin)))
        else $error("address moved under strobe");

    a_cycle_spacing: assert property (
        @(posedge clk) disable iff (!resetn)
        $rose(strobe_q) |-> since_q >= CNT_WIDTH'(CYCLE_CYC))
        else $error("access cycle too short");

    a_write_mode: assert property (
        @(posedge clk) disable iff (!resetn)
        take && req_write |=> rw_sel ##1 sel_strobe)
        else $error("write mode not set before strobe");

    a_read_answer: assert property (
        @(posedge clk) disable iff (!resetn)
        $fell(strobe_q) |-> rsp_valid && $past(state_q) == ST_STROBE)
        else $error("answer not at strobe fall");

    a_read_mode: assert property (
        @(posedge clk) disable iff (!resetn)
        take && !req_write |=> !rw_sel ##1 sel_strobe)
        else $error("read mode not set before strobe");

    a_data_setup: assert property (
        @(posedge clk) disable iff (!resetn)
        take && req_write |=> din_pin == $past(req_wdata))
        else $error("write data not presented");

    a_addr_taken: assert property (
        @(posedge clk) disable iff (!resetn)
        take |=> addr_pin == $past(req_addr))
        else $error("address not presented");

    a_idle_low: assert property (
        @(posedge clk) disable iff (!resetn)
        (state_q == ST_IDLE) |-> !sel_strobe)
        else $error("strobe high while idle");

    a_strobe_follows: assert property (
        @(posedge clk) disable iff (!resetn)
        take |=> !sel_strobe ##1 sel_strobe)
        else $error("strobe not raised after setup");

    a_pins_hold: assert property (
        @(posedge clk) disable iff (!resetn)
        !take |=> $stable(addr_pin) && $stable(rw_sel) && $stable(din_pin))
        else $error("memory pins moved without a request");

    a_answer_pulse: assert property (
        @(posedge clk) disable iff (!resetn)
        rsp_valid |=> !rsp_valid)
        else $error("answer longer than one cycle");

    a_write_rdata_zero: assert property (
        @(posedge clk) disable iff (!resetn)
        rsp_valid && rw_sel |-> !rsp_rdata && !rsp_error)
        else $error("write answer carries read data");
endmodule // sram_host
`default_nettype wire

/* sram_host_pkg.sv */
`default_nettype none
package sram_host_pkg;
    localparam int ADDR_WIDTH      = 12;
    localparam int ROW_LSB         = 0;
    localparam int ROW_WIDTH       = 6;
    localparam int COL_LSB         = 6;
    localparam int COL_WIDTH       = 6;
    localparam int CLK_PERIOD_NS   = 20;
    // strobe timing in ns
    localparam int READ_STROBE_WIDTH_NS     = 200;
    localparam int WRITE_STROBE_WIDTH_NS    = 200;
    localparam int READ_STROBE_RECOVERY_NS  = 125;
    localparam int WRITE_STROBE_RECOVERY_NS = 125;
    localparam int ACCESS_CYCLE_PERIOD_NS   = 350;
    // least times round up
    localparam int READ_WIDTH_CYC  = (READ_STROBE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WRITE_WIDTH_CYC = (WRITE_STROBE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int READ_REC_CYC    =
        (READ_STROBE_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WRITE_REC_CYC   =
        (WRITE_STROBE_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CYCLE_CYC       = (ACCESS_CYCLE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_WIDTH       = 8;
    localparam logic [CNT_WIDTH-1:0] CNT_ZERO = 8'h00;
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b001,
        ST_STROBE = 3'b010,
        ST_RECOV  = 3'b100
    } state_type;
endpackage
`default_nettype wire

/* sram_pins_if.sv */
`default_nettype none
interface sram_pins_if;
    logic       sample;
    logic       dout_sync;
    logic       doutn_sync;
    modport ctrl (output sample, input dout_sync, input doutn_sync);
    modport sync (input sample, output dout_sync, output doutn_sync);
endinterface
`default_nettype wire

/* sram_timer.sv */
`default_nettype none
module sram_timer
    import sram_host_pkg::*;
(
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 resetn,
    // control
    input  wire logic                 load,
    input  wire logic [CNT_WIDTH-1:0] value,
    output logic                      done
);
    logic [CNT_WIDTH-1:0] count_q;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            count_q <= CNT_ZERO;
        end else if (load) begin
            count_q <= value;
        end else if (count_q != CNT_ZERO) begin
            count_q <= count_q - 8'h01;
        end
    end

    assign done = (count_q == CNT_ZERO);
endmodule // sram_timer
`default_nettype wire

/* sram_out_sync.sv */
`default_nettype none
module sram_out_sync (
    // clock and reset
    input  wire logic clk,
    input  wire logic resetn,
    // pins
    input  wire logic dout_pin,
    input  wire logic doutn_pin,
    // to controller
    sram_pins_if.sync pins
);
    logic [2:0] d_q;
    logic [2:0] n_q;
    logic       d_stable_q;
    logic       n_stable_q;

    // third stage agreement filters a lone glitch
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            d_q        <= 3'h0;
            n_q        <= 3'h0;
            d_stable_q <= 1'b0;
            n_stable_q <= 1'b0;
        end else begin
            d_q <= {d_q[1:0], dout_pin};
            n_q <= {n_q[1:0], doutn_pin};
            // outputs only mean something while the strobe is up
            if (pins.sample && (d_q[1] == d_q[2])) begin
                d_stable_q <= d_q[2];
            end
            if (pins.sample && (n_q[1] == n_q[2])) begin
                n_stable_q <= n_q[2];
            end
        end
    end

    assign pins.dout_sync  = d_stable_q;
    assign pins.doutn_sync = n_stable_q;
endmodule // sram_out_sync
`default_nettype wire

/* sram_dev_model.sv */
`default_nettype none
module sram_dev_model
    import sram_host_pkg::*;
#(
    parameter realtime ACC_NS = 100.0
) (
    // memory pins
    input  wire logic                  sel_strobe,
    input  wire logic                  rw_sel,
    input  wire logic [ADDR_WIDTH-1:0] addr_pin,
    input  wire logic                  din_pin,
    output var  logic                  dout_pin,
    output var  logic                  doutn_pin,
    // fault injection and timing faults seen
    input  wire logic                  fault,
    output var  int                    viol
);
    timeunit 1ns;
    timeprecision 1ps;
    logic    cell_q [64][64];
    logic    rw_q;
    logic    bit_q;
    realtime t_rise;
    realtime t_fall;
    realtime t_chg;

    initial begin
        viol = 0;
        t_rise = -1000.0;
        t_fall = -1000.0;
        t_chg = 0.0;
        dout_pin = 1'b0;
        doutn_pin = 1'b0;
        foreach (cell_q[r, c]) cell_q[r][c] = 1'b0;
    end

    always @(addr_pin or rw_sel or din_pin) t_chg = $realtime;

    ////////////////////////////////////////////////////////////////////////
    // setup before strobe
    always @(posedge sel_strobe) begin
        if ($realtime - t_chg < 10.0) viol++;
        if ($realtime - t_fall < 125.0 || $realtime - t_rise < 350.0) viol++;
        t_rise = $realtime;
        rw_q = rw_sel;
        if (rw_sel) cell_q[addr_pin[5:0]][addr_pin[11:6]] = din_pin;
        bit_q = cell_q[addr_pin[5:0]][addr_pin[11:6]];
        // slow answer: data only after the access delay
        #(ACC_NS);
        if (sel_strobe && !rw_q) begin
            dout_pin = bit_q | fault;
            doutn_pin = !bit_q | fault;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // strobe width
    always @(negedge sel_strobe) begin
        if ($realtime - t_rise < 200.0) viol++;
        t_fall = $realtime;
        dout_pin = 1'b0;
        doutn_pin = 1'b0;
    end
endmodule // sram_dev_model
`default_nettype wire

/* sram_host_tb.sv */
`default_nettype none
module sram_host_tb;
    import sram_host_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk;
    logic        resetn;
    logic        req_valid;
    logic        req_ready;
    logic        req_write;
    logic [11:0] req_addr;
    logic        req_wdata;
    logic        rsp_valid;
    logic        rsp_rdata;
    logic        rsp_error;
    logic        sel_strobe;
    logic        rw_sel;
    logic [11:0] addr_pin;
    logic        din_pin;
    logic        dout_pin;
    logic        doutn_pin;
    logic        fault;
    int          viol;
    int          mismatches;
    int          n_tests;
    int          cycles;
    int          ref_mem [4096];
    logic [11:0] corner [5] = '{12'h000, 12'h03F, 12'hFC0, 12'hFFF, 12'h041};

    sram_host u_sram_host (.clk(clk), .resetn(resetn), .req_valid(req_valid),
        .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr),
        .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .rsp_error(rsp_error), .sel_strobe(sel_strobe), .rw_sel(rw_sel),
        .addr_pin(addr_pin), .din_pin(din_pin), .dout_pin(dout_pin),
        .doutn_pin(doutn_pin));
    sram_dev_model u_sram_dev_model (.sel_strobe(sel_strobe), .rw_sel(rw_sel),
        .addr_pin(addr_pin), .din_pin(din_pin), .dout_pin(dout_pin),
        .doutn_pin(doutn_pin), .fault(fault), .viol(viol));

    initial begin
        clk = 1'b0;
        forever #10 clk = !clk;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // one access; scr scrambles the request lines right after the take
    task automatic access(input logic w, input logic [11:0] a, input logic d,
                          input logic scr);
        int n;
        n = 0;
        @(negedge clk);
        req_valid = 1'b1;
        req_write = w;
        req_addr = a;
        req_wdata = d;
        while (req_ready !== 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        req_valid = 1'b0;
        if (scr) begin
            req_write = !w;
            req_addr = 12'($urandom);
            req_wdata = !d;
        end
        n = 0;
        while (rsp_valid !== 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        check("latency", n, w ? WRITE_WIDTH_CYC + 1 : READ_WIDTH_CYC + 1);
        check("addr pins", addr_pin, a);
        check("mode pin", rw_sel, w);
        check("strobe low", sel_strobe, 0);
        check("spacing", req_ready, 0);
        if (w) begin
            ref_mem[a] = d;
            check("data pin", din_pin, d);
        end
        check("error", rsp_error, fault & !w);
        if (!fault) check("read bit", rsp_rdata, w ? 0 : ref_mem[a]);
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            results();
        end
    end

    initial begin
        resetn = 1'b0;
        req_valid = 1'b0;
        req_write = 1'b0;
        req_addr = 12'h000;
        req_wdata = 1'b0;
        fault = 1'b0;
        void'($urandom(32'h431A));
        repeat (6) @(negedge clk);
        resetn = 1'b1;
        check("ready after reset", req_ready, 1);
        check("strobe idle", sel_strobe, 0);
        foreach (corner[i]) access(1'b1, corner[i], i[0], 1'b0);
        foreach (corner[i]) access(1'b0, corner[i], 1'b0, 1'b0);
        $display("corner test done");
        repeat (40) access(1'($urandom), 12'($urandom), 1'($urandom), 1'b1);
        $display("random test done");
        fault = 1'b1;
        access(1'b0, 12'hFFF, 1'b0, 1'b0);
        access(1'b0, 12'h000, 1'b0, 1'b0);
        fault = 1'b0;
        access(1'b0, 12'h03F, 1'b0, 1'b0);
        $display("fault test done");
        check("device timing", viol, 0);
        results();
    end
endmodule // sram_host_tb
`default_nettype wire
